// ===== rtl/sidt_pkg.sv
// constants for split interrupt descriptor tracking
package sidt_pkg;
  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0] SIDT_OFS_STATUS = 8'h00;
  localparam logic [7:0] SIDT_OFS_CNT_LO = 8'h04;
  localparam logic [7:0] SIDT_OFS_CNT_MID = 8'h08;
  localparam logic [7:0] SIDT_OFS_CNT_LAST = 8'h0c;
  localparam logic [7:0] SIDT_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] SIDT_OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] SIDT_OFS_SUMMARY = 8'h18;
  // field layout of the status word
  localparam int SIDT_SS_MASK_LSB = 0;
  localparam int SIDT_RESULT_LSB = 8;
  localparam int SIDT_RESULT_W = 3;
  localparam int SIDT_NUM_MF = 8;
  // field layout of the count words
  localparam int SIDT_CS_MASK_LSB = 0;
  localparam int SIDT_CNT_W = 8;
  // result bit positions inside one per-microframe result
  localparam int SIDT_RES_XERR = 0;
  localparam int SIDT_RES_BABBLE = 1;
  localparam int SIDT_RES_UNDERRUN = 2;
  // summary word bits
  localparam int SIDT_SUM_XERR = 0;
  localparam int SIDT_SUM_BABBLE = 1;
  // interrupt status and mask bits
  localparam int SIDT_IRQ_W = 5;
  localparam int SIDT_IRQ_SS_DONE = 0;
  localparam int SIDT_IRQ_CS_DONE = 1;
  localparam int SIDT_IRQ_XERR = 2;
  localparam int SIDT_IRQ_BABBLE = 3;
  localparam int SIDT_IRQ_UNDERRUN = 4;
  // count memory: word 0 holds counts 0..2, word 1 counts 3..6, word 2 count 7
  localparam int SIDT_MEM_DEPTH = 3;
  localparam logic [1:0] SIDT_MEM_LO = 2'h0;
  localparam logic [1:0] SIDT_MEM_MID = 2'h1;
  localparam logic [1:0] SIDT_MEM_LAST = 2'h2;
  localparam logic [31:0] SIDT_MEM_LO_KEEP = 32'hffffff00;
  localparam logic [31:0] SIDT_MEM_MID_KEEP = 32'hffffffff;
  localparam logic [31:0] SIDT_MEM_LAST_KEEP = 32'h000000ff;
  // reset values
  localparam logic [7:0] SIDT_MASK_RST = 8'h00;
  localparam logic [23:0] SIDT_RESULT_RST = 24'h000000;
  localparam logic [4:0] SIDT_IRQ_RST = 5'h00;
endpackage

// ===== rtl/sidt_cnt_mem.sv
// small byte-writable memory holding the per-microframe received counts
`timescale 1ns/1ps
`default_nettype none
module sidt_cnt_mem
  import sidt_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // write port
  input wire logic we_in,
  input wire logic [1:0] waddr_in,
  input wire logic [3:0] wbe_in,
  input wire logic [31:0] wdata_in,
  // read port, data one cycle later
  input wire logic [1:0] raddr_in,
  output logic [31:0] rdata_out
);
  logic [31:0] mem_r [SIDT_MEM_DEPTH];

  // reset clears every word so unread counts never show unknowns
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < SIDT_MEM_DEPTH; i++)
        mem_r[i] <= 32'h00000000;
      rdata_out <= 32'h00000000;
    end
    else
    begin
      if (we_in)
      begin
        for (int b = 0; b < 4; b++)
          if (wbe_in[b])
            mem_r[waddr_in][b*8 +: 8] <= wdata_in[b*8 +: 8];
      end
      rdata_out <= (raddr_in < 2'(SIDT_MEM_DEPTH)) ? mem_r[raddr_in]
                                                  : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/sidt_top.sv
// split interrupt descriptor tracking: masks, per-microframe results, counts
// Behaviour
// RULE1 - microframe n done with start mask n set and frame match records count n
// RULE2 - each count write replaces the old count, never accumulates
// RULE3 - counts 0-2 in low count word, 3-6 mid word, 7 last word
// RULE4 - software sets complete mask bits before a transfer, any combination
// RULE5 - after complete split of microframe n, hardware clears complete mask n
// RULE6 - complete split issued only where its mask bit set, IN only
// RULE7 - start mask 01, complete mask 04: start in mf0, complete in mf2
// RULE8 - 3-bit result per microframe, result 0 at bits 10:8, step three
// RULE9 - result bit0 transaction error, bit1 babble IN, bit2 underrun OUT
// RULE10 - for IN, software sets start mask bits only for mf0 to mf3
// RULE11 - summary babble and error flags are OR of all result bits
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sidt_top
  import sidt_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // microframe scheduling from the frame logic
  input wire logic uf_start_in,
  input wire logic [2:0] uf_idx_in,
  input wire logic frame_match_in,
  input wire logic token_in_in,
  // split issue requests to the transaction engine
  output logic ss_issue_out,
  output logic cs_issue_out,
  // transaction completion from the transaction engine
  input wire logic done_in,
  input wire logic done_is_cs_in,
  input wire logic [2:0] done_idx_in,
  input wire logic [7:0] rx_bytes_in,
  input wire logic xerr_in,
  input wire logic babble_in,
  input wire logic underrun_in,
  // summaries and interrupt
  output logic babble_flag_out,
  output logic xerr_flag_out,
  output logic irq_out
);

  typedef struct packed {
    logic [7:0] ss_mask;
    logic [7:0] cs_mask;
    logic [23:0] result;
    logic [4:0] irq_stat;
    logic [4:0] irq_mask;
    logic [31:0] rd_hold;
    logic [31:0] rd_keep;
    logic sum_babble;
    logic sum_xerr;
  } sidt_state_s;

  sidt_state_s st_r;
  sidt_state_s st_nxt;

  // count memory ports
  logic mem_we;
  logic [1:0] mem_waddr;
  logic [3:0] mem_wbe;
  logic [31:0] mem_wdata;
  logic [1:0] mem_raddr;
  logic [31:0] mem_rdata;

  // word and byte lane of count n inside the count memory
  function automatic logic [3:0] cnt_lane(input logic [2:0] idx);
    logic [3:0] lane;
    lane = 4'h0;
    if (idx <= 3'h2)
      lane = {SIDT_MEM_LO, 2'(idx + 3'h1)}; // see RULE3
    else if (idx <= 3'h6)
      lane = {SIDT_MEM_MID, 2'(idx - 3'h3)}; // see RULE3
    else
      lane = {SIDT_MEM_LAST, 2'h0}; // see RULE3
    return lane;
  endfunction

  // one-hot vector for a microframe index
  function automatic logic [7:0] mf_bit(input logic [2:0] idx);
    return 8'h01 << idx;
  endfunction

  // OR of one result bit over all eight microframes
  function automatic logic any_result(input logic [23:0] res,
                                      input int pos);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < SIDT_NUM_MF; i++)
      hit = hit | res[i*SIDT_RESULT_W + pos];
    return hit;
  endfunction

  logic [3:0] lane;
  logic [2:0] res_bits;
  logic [7:0] clr_ss;
  logic [7:0] clr_cs;
  logic [4:0] irq_set;
  logic [23:0] res_tmp;

  // issue decisions are combinational so they line up with the tick
  always_comb
  begin
    ss_issue_out = uf_start_in & frame_match_in
                   & st_r.ss_mask[uf_idx_in]; // see RULE7
    cs_issue_out = uf_start_in & frame_match_in & token_in_in
                   & st_r.cs_mask[uf_idx_in]; // see RULE6
  end

  // completion: results, mask clears and count capture
  always_comb
  begin
    lane = cnt_lane(done_idx_in);
    // babble only meaningful on IN, underrun only on OUT
    res_bits = {underrun_in & ~token_in_in,
                babble_in & token_in_in,
                xerr_in}; // see RULE9
    clr_ss = 8'h00;
    clr_cs = (done_in & done_is_cs_in) ? mf_bit(done_idx_in)
                                       : 8'h00; // see RULE5
    mem_we = done_in & frame_match_in
             & st_r.ss_mask[done_idx_in]; // see RULE1
    mem_waddr = lane[3:2];
    mem_wbe = 4'(4'h1 << lane[1:0]);
    // plain overwrite of the lane, no accumulation
    mem_wdata = {4{rx_bytes_in}}; // see RULE2
    mem_raddr = reg_addr_in[3:2] - 2'h1;
    irq_set = 5'h00;
    if (done_in)
    begin
      irq_set[SIDT_IRQ_SS_DONE] = ~done_is_cs_in;
      irq_set[SIDT_IRQ_CS_DONE] = done_is_cs_in;
      irq_set[SIDT_IRQ_XERR] = res_bits[SIDT_RES_XERR];
      irq_set[SIDT_IRQ_BABBLE] = res_bits[SIDT_RES_BABBLE];
      irq_set[SIDT_IRQ_UNDERRUN] = res_bits[SIDT_RES_UNDERRUN];
    end
  end

  // next-state of the whole block
  always_comb
  begin
    st_nxt = st_r;
    res_tmp = st_r.result;
    if (done_in)
      res_tmp[done_idx_in*SIDT_RESULT_W +: SIDT_RESULT_W] =
        res_bits; // see RULE8
    st_nxt.result = res_tmp;
    st_nxt.sum_babble = any_result(res_tmp, SIDT_RES_BABBLE); // see RULE11
    st_nxt.sum_xerr = any_result(res_tmp, SIDT_RES_XERR); // see RULE11
    // software write wins the mask; otherwise hardware clears the complete mask only
    st_nxt.ss_mask = st_r.ss_mask & ~clr_ss;
    st_nxt.cs_mask = st_r.cs_mask & ~clr_cs; // see RULE5
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        SIDT_OFS_STATUS:
          st_nxt.ss_mask = reg_wdata_in[SIDT_SS_MASK_LSB +: 8];
        SIDT_OFS_CNT_LO:
          st_nxt.cs_mask = reg_wdata_in[SIDT_CS_MASK_LSB +: 8];
        SIDT_OFS_IRQ_MASK:
          st_nxt.irq_mask = reg_wdata_in[SIDT_IRQ_W-1:0];
        default:
          st_nxt.irq_mask = st_r.irq_mask;
      endcase
    end
    // sticky events; a read clears but a same-cycle event survives
    st_nxt.irq_stat = st_r.irq_stat | irq_set;
    if (reg_rd_in && reg_addr_in == SIDT_OFS_IRQ_STAT)
      st_nxt.irq_stat = irq_set;
    // read data: register part held here, count part from memory
    st_nxt.rd_hold = 32'h00000000;
    st_nxt.rd_keep = 32'h00000000;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        SIDT_OFS_STATUS:
          st_nxt.rd_hold = {st_r.result, st_r.ss_mask};
        SIDT_OFS_CNT_LO:
        begin
          st_nxt.rd_hold = {24'h000000, st_r.cs_mask};
          st_nxt.rd_keep = SIDT_MEM_LO_KEEP;
        end
        SIDT_OFS_CNT_MID:
          st_nxt.rd_keep = SIDT_MEM_MID_KEEP;
        SIDT_OFS_CNT_LAST:
          st_nxt.rd_keep = SIDT_MEM_LAST_KEEP;
        SIDT_OFS_IRQ_STAT:
          st_nxt.rd_hold = {27'h0000000, st_r.irq_stat};
        SIDT_OFS_IRQ_MASK:
          st_nxt.rd_hold = {27'h0000000, st_r.irq_mask};
        SIDT_OFS_SUMMARY:
          st_nxt.rd_hold = {30'h00000000, st_r.sum_babble, st_r.sum_xerr};
        default:
          st_nxt.rd_hold = 32'h00000000;
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st_r.ss_mask <= SIDT_MASK_RST;
      st_r.cs_mask <= SIDT_MASK_RST;
      st_r.result <= SIDT_RESULT_RST;
      st_r.irq_stat <= SIDT_IRQ_RST;
      st_r.irq_mask <= SIDT_IRQ_RST;
      st_r.rd_hold <= 32'h00000000;
      st_r.rd_keep <= 32'h00000000;
      st_r.sum_babble <= 1'b0;
      st_r.sum_xerr <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  sidt_cnt_mem u_cnt_mem (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wbe_in(mem_wbe),
    .wdata_in(mem_wdata),
    .raddr_in(mem_raddr),
    .rdata_out(mem_rdata)
  );

  // outputs, all from flip-flops apart from the issue strobes
  assign reg_rdata_out = st_r.rd_hold | (mem_rdata & st_r.rd_keep);
  assign babble_flag_out = st_r.sum_babble;
  assign xerr_flag_out = st_r.sum_xerr;
  assign irq_out = |(st_r.irq_stat & st_r.irq_mask);
endmodule
`default_nettype wire

// ===== sim/sidt_top_asserts.sv
// port-level assertions for split interrupt descriptor tracking
`timescale 1ns/1ps
`default_nettype none
module sidt_top_asserts
  import sidt_pkg::*;
(
  // clock, reset and register port
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // scheduling, completion and summaries
  input wire logic uf_start_in,
  input wire logic frame_match_in,
  input wire logic token_in_in,
  input wire logic ss_issue_out,
  input wire logic cs_issue_out,
  input wire logic done_in,
  input wire logic xerr_in,
  input wire logic babble_in,
  input wire logic babble_flag_out,
  input wire logic xerr_flag_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // issues only inside a matching microframe
  a_ss_gate: assert property (
    ss_issue_out |-> uf_start_in && frame_match_in) else $error("bad ss");
  a_cs_gate: assert property (
    cs_issue_out |-> uf_start_in && frame_match_in && token_in_in)
    else $error("bad cs");
  // flags follow the results one cycle after completion
  a_babble_flag: assert property (
    done_in && token_in_in && babble_in |=> babble_flag_out)
    else $error("babble flag missing");
  a_xerr_flag: assert property (
    done_in && xerr_in |=> xerr_flag_out) else $error("xerr flag missing");
  a_summary_read: assert property (
    reg_rd_in && reg_addr_in == SIDT_OFS_SUMMARY |=> reg_rdata_out ==
    {30'h0, $past(babble_flag_out), $past(xerr_flag_out)})
    else $error("summary word wrong");
  // read data stand one cycle only, unmapped reads give zero
  a_rdata_idle: assert property (
    !reg_rd_in |=> reg_rdata_out == 32'h0) else $error("stray read data");
  a_unmapped_zero: assert property (
    reg_rd_in && reg_addr_in > SIDT_OFS_SUMMARY |=> reg_rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (
    $past(rst_in) |-> !babble_flag_out && !xerr_flag_out && !irq_out)
    else $error("outputs set after reset");
  c_cs: cover property (cs_issue_out);
  c_babble: cover property (done_in && babble_in);
  c_irq: cover property (irq_out);
endmodule
bind sidt_top sidt_top_asserts u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .uf_start_in(uf_start_in),
  .frame_match_in(frame_match_in), .token_in_in(token_in_in),
  .ss_issue_out(ss_issue_out), .cs_issue_out(cs_issue_out),
  .done_in(done_in), .xerr_in(xerr_in), .babble_in(babble_in),
  .babble_flag_out(babble_flag_out), .xerr_flag_out(xerr_flag_out),
  .irq_out(irq_out));
`default_nettype wire

// ===== sim/sidt_xact_model.sv
// transaction engine and hub model answering split issues
`timescale 1ns/1ps
`default_nettype none
module sidt_xact_model (
  // issue requests and answer shaping
  input wire logic clk_in,
  input wire logic ss_issue_in,
  input wire logic cs_issue_in,
  input wire logic [2:0] idx_in,
  input wire logic [3:0] lat_in,
  input wire logic [7:0] rx_in,
  input wire logic [2:0] err_in,
  // completion back to the block
  output logic done_out = 1'b0,
  output logic done_cs_out = 1'b0,
  output logic [2:0] idx_out = 3'h0,
  output logic [7:0] rx_out = 8'h00,
  output logic [2:0] err_out = 3'h0
);
  logic pend_r = 1'b0;
  logic [3:0] wait_r = 4'h0;
  // byte count toggles outside done so a stale sample is caught
  always @(posedge clk_in)
  begin
    done_out <= 1'b0;
    rx_out <= ~rx_out;
    err_out <= ~err_out;
    if (ss_issue_in || cs_issue_in)
    begin
      pend_r <= 1'b1;
      wait_r <= lat_in;
      done_cs_out <= cs_issue_in;
      idx_out <= idx_in;
    end
    else if (pend_r && wait_r != 4'h0)
      wait_r <= wait_r - 4'h1;
    else if (pend_r)
    begin
      pend_r <= 1'b0;
      done_out <= 1'b1;
      rx_out <= rx_in;
      err_out <= err_in;
    end
  end
endmodule
`default_nettype wire

// ===== sim/split_interrupt_descriptor_tracking_bench.sv
// self-checking bench for split interrupt descriptor tracking
`timescale 1ns/1ps
`default_nettype none
module split_interrupt_descriptor_tracking_bench;
  import sidt_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, us = 1'b0;
  logic fm = 1'b1, tk = 1'b1, ss, cs, dn, dcs, bf, xf, irq;
  logic [7:0] a = 8'h00, p_rx = 8'h00, rx;
  logic [31:0] wd = 32'h0, rdat;
  logic [2:0] ix = 3'h0, p_err = 3'h0, di, er;
  logic [3:0] p_lat = 4'h0;
  logic [23:0] res;
  int n_fail = 0, samples_checked = 0;
  sidt_top dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(a),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
    .uf_start_in(us), .uf_idx_in(ix), .frame_match_in(fm), .token_in_in(tk),
    .ss_issue_out(ss), .cs_issue_out(cs), .done_in(dn), .done_is_cs_in(dcs),
    .done_idx_in(di), .rx_bytes_in(rx), .xerr_in(er[0]), .babble_in(er[1]),
    .underrun_in(er[2]), .babble_flag_out(bf), .xerr_flag_out(xf),
    .irq_out(irq));
  sidt_xact_model far (.clk_in(clk_in), .ss_issue_in(ss), .cs_issue_in(cs),
    .idx_in(ix), .lat_in(p_lat), .rx_in(p_rx), .err_in(p_err),
    .done_out(dn), .done_cs_out(dcs), .idx_out(di), .rx_out(rx),
    .err_out(er));
  // 10 MHz clock
  initial
    forever #50 clk_in = ~clk_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] ad, input logic [31:0] d);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    // idle edge so a following call never reassigns a strobe at once
    @(posedge clk_in);
  endtask
  task automatic rreg(input logic [7:0] ad, input logic [31:0] exp);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    // read data stand only in the cycle after the strobe
    @(negedge clk_in);
    chk(rdat, exp);
    @(posedge clk_in);
  endtask
  // one microframe start, then wait for the far side to finish
  task automatic uf(input logic [2:0] i, input logic t, input logic e_ss,
                    input logic e_cs);
    ix <= i;
    tk <= t;
    us <= 1'b1;
    #1 chk({ss, cs}, {e_ss, e_cs});
    @(posedge clk_in);
    us <= 1'b0;
    // look at falling edges, clear of the far side's launch edge
    for (int k = 0; k < 12 && dn !== 1'b1; k++)
      @(negedge clk_in);
    chk(dn, e_ss | e_cs);
    repeat (2) @(posedge clk_in);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog, far beyond the under 160 cycles the tests need
  initial
  begin
    #3000000;
    n_fail++;
    stop_test;
  end
  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rreg(SIDT_OFS_STATUS, 32'h0);
    wreg(SIDT_OFS_IRQ_MASK, 32'h1f);
    rreg(SIDT_OFS_IRQ_MASK, 32'h1f);
    rreg(SIDT_OFS_SUMMARY, 32'h0);
    wreg(SIDT_OFS_STATUS, 32'h01);
    wreg(SIDT_OFS_CNT_LO, 32'h04);
    p_rx <= 8'h11;
    uf(3'h0, 1'b1, 1'b1, 1'b0);
    uf(3'h2, 1'b1, 1'b0, 1'b1);
    rreg(SIDT_OFS_CNT_LO, 32'h1100);
    fm <= 1'b0;
    uf(3'h0, 1'b1, 1'b0, 1'b0);
    fm <= 1'b1;
    p_rx <= 8'h22;
    p_lat <= 4'h3;
    uf(3'h0, 1'b1, 1'b1, 1'b0);
    rreg(SIDT_OFS_CNT_LO, 32'h2200);
    chk(irq, 1'b1);
    rreg(SIDT_OFS_IRQ_STAT, 32'h03);
    rreg(SIDT_OFS_IRQ_STAT, 32'h0);
    chk(irq, 1'b0);
    // every microframe: IN for 0..3, OUT for 4..7, all error inputs set
    wreg(SIDT_OFS_CNT_LO, 32'hff);
    p_err <= 3'h7;
    for (int i = 0; i < 8; i++)
    begin
      if (i == 0)
        wreg(SIDT_OFS_STATUS, 32'h0f);
      if (i == 4)
        wreg(SIDT_OFS_STATUS, 32'hf0);
      p_rx <= 8'(i + 1);
      p_lat <= 4'(i);
      uf(3'(i), i < 4, 1'b1, i < 4);
      res[3 * i +: 3] = (i < 4) ? 3'h3 : 3'h5;
    end
    rreg(SIDT_OFS_STATUS, {res, 8'hf0});
    rreg(SIDT_OFS_CNT_LO, 32'h030201f0);
    rreg(SIDT_OFS_CNT_MID, 32'h07060504);
    rreg(SIDT_OFS_CNT_LAST, 32'h08);
    rreg(SIDT_OFS_SUMMARY, 32'h3);
    chk({bf, xf}, 32'h3);
    rreg(SIDT_OFS_IRQ_STAT, 32'h1f);
    wreg(SIDT_OFS_CNT_MID, 32'h0);
    rreg(SIDT_OFS_CNT_MID, 32'h07060504);
    rreg(8'h1c, 32'h0);
    // masked event: status set, line stays low
    wreg(SIDT_OFS_IRQ_MASK, 32'h0);
    p_err <= 3'h0;
    uf(3'h4, 1'b0, 1'b1, 1'b0);
    chk(irq, 1'b0);
    rreg(SIDT_OFS_IRQ_STAT, 32'h01);
    stop_test;
  end
endmodule
`default_nettype wire
